// file: ued_consts.vh
// constants for the enumeration descriptor responder
`ifndef UED_CONSTS_VH
`define UED_CONSTS_VH
`define UED_REQ_GET_DESC   8'h06
`define UED_RT_DEV_IN      8'h80
`define UED_DT_DEVICE      8'h01
`define UED_DT_CONFIG      8'h02
`define UED_DT_STRING      8'h03
`define UED_DT_IFACE       8'h04
`define UED_DT_EP          8'h05
`define UED_DEV_LEN        8'h12
`define UED_CFG_TOTAL      8'h49
`define UED_STR0_LEN       8'h0e
`define UED_STRN_LEN       8'h16
`define UED_USB_REL_LO     8'h00
`define UED_USB_REL_HI     8'h01
`define UED_EP0_MAXPKT     8'h08
`define UED_NUM_CFG        8'h01
`define UED_CFG_ATTR       8'h80
`define UED_CFG_POWER      8'hc8
`define UED_IFACE_NUM      8'h01
`define UED_VENDOR_CLASS   8'hff
`define UED_EP_ADDR        8'h81
`define UED_EP_ISO         8'h01
`define UED_EP_INTERVAL    8'h01
`define UED_PKT_BYTES      4'h8
`define UED_ROM_STR0       8'h00
`define UED_ROM_STRN       8'h10
`define UED_ROM_DEV        8'h30
`define UED_ROM_CFG        8'h50
// packet sizes per alternate setting, high and low bandwidth tables
`define UED_MPS_H1         16'h01c0
`define UED_MPS_H2         16'h02c0
`define UED_MPS_H3         16'h03c0
`define UED_MPS_L1         16'h0140
`define UED_MPS_L2         16'h0268
`define UED_MPS_L3         16'h0380
`endif

// file: ued_desc_rom.v
// descriptor byte store with registered read data
`timescale 1ns/1ps
`include "ued_consts.vh"
module ued_desc_rom (
	input  wire        ref_clk_i,
	input  wire [7:0]  addr_i,
	input  wire [15:0] vendor_id_i,
	input  wire [15:0] product_id_i,
	input  wire        bw_low_i,
	output reg  [7:0]  data_o
);
	reg  [7:0]  rom_byte;
	reg  [7:0]  off;
	reg  [15:0] mps;
	reg  [1:0]  alt;
	reg  [7:0]  k;
	always @* begin
		off = addr_i - `UED_ROM_CFG;
		rom_byte = 8'h00;
		mps = 16'h0000;
		alt = 2'd0;
		k = 8'h00;
		if (addr_i < `UED_ROM_STRN) begin
			// language list in order
			case (addr_i[3:0])
				4'h0: rom_byte = `UED_STR0_LEN;
				4'h1: rom_byte = `UED_DT_STRING;
				4'h2: rom_byte = 8'h04; 4'h3: rom_byte = 8'h09;
				4'h4: rom_byte = 8'h04; 4'h5: rom_byte = 8'h0c;
				4'h6: rom_byte = 8'h04; 4'h7: rom_byte = 8'h07;
				4'h8: rom_byte = 8'h04; 4'h9: rom_byte = 8'h10;
				4'ha: rom_byte = 8'h0c; 4'hb: rom_byte = 8'h0a;
				4'hc: rom_byte = 8'h04; 4'hd: rom_byte = 8'h16;
				default: rom_byte = 8'h00;
			endcase
		end else if (addr_i < `UED_ROM_DEV) begin
			k = addr_i - `UED_ROM_STRN;
			if (k == 8'h00) rom_byte = `UED_STRN_LEN;
			else if (k == 8'h01) rom_byte = `UED_DT_STRING;
			else if (k[0]) rom_byte = 8'h00;
			else begin
				case (k[4:1])
					4'h1: rom_byte = 8'h55; 4'h2: rom_byte = 8'h53;
					4'h3: rom_byte = 8'h42; 4'h4: rom_byte = 8'h20;
					4'h5: rom_byte = 8'h43; 4'h6: rom_byte = 8'h61;
					4'h7: rom_byte = 8'h6d; 4'h8: rom_byte = 8'h65;
					4'h9: rom_byte = 8'h72; 4'ha: rom_byte = 8'h61;
					default: rom_byte = 8'h00;
				endcase
			end
		end else if (addr_i < `UED_ROM_CFG) begin
			k = addr_i - `UED_ROM_DEV;
			case (k[4:0])
				5'd0:  rom_byte = `UED_DEV_LEN;
				5'd1:  rom_byte = `UED_DT_DEVICE;
				5'd2:  rom_byte = `UED_USB_REL_LO;
				5'd3:  rom_byte = `UED_USB_REL_HI;
				5'd7:  rom_byte = `UED_EP0_MAXPKT;
				5'd8:  rom_byte = vendor_id_i[7:0];
				5'd9:  rom_byte = vendor_id_i[15:8];
				5'd10: rom_byte = product_id_i[7:0];
				5'd11: rom_byte = product_id_i[15:8];
				5'd12: rom_byte = `UED_USB_REL_LO;
				5'd13: rom_byte = `UED_USB_REL_HI;
				5'd17: rom_byte = `UED_NUM_CFG;
				default: rom_byte = 8'h00;
			endcase
		end else if (off < 8'd9) begin
			case (off[3:0])
				4'd0: rom_byte = 8'h09;
				4'd1: rom_byte = `UED_DT_CONFIG;
				4'd2: rom_byte = `UED_CFG_TOTAL;
				4'd4: rom_byte = 8'h01;
				4'd5: rom_byte = 8'h01;
				4'd7: rom_byte = `UED_CFG_ATTR;
				4'd8: rom_byte = `UED_CFG_POWER;
				default: rom_byte = 8'h00;
			endcase
		end else begin
			// four 16-byte groups: interface then endpoint
			k = off - 8'd9;
			alt = k[5:4];
			case (alt)
				2'd1: mps = bw_low_i ? `UED_MPS_L1 : `UED_MPS_H1;
				2'd2: mps = bw_low_i ? `UED_MPS_L2 : `UED_MPS_H2;
				2'd3: mps = bw_low_i ? `UED_MPS_L3 : `UED_MPS_H3;
				default: mps = 16'h0000;
			endcase
			case (k[3:0])
				4'd0:  rom_byte = 8'h09;
				4'd1:  rom_byte = `UED_DT_IFACE;
				4'd2:  rom_byte = `UED_IFACE_NUM;
				4'd3:  rom_byte = {6'h00, alt};
				4'd4:  rom_byte = 8'h01;
				4'd5:  rom_byte = `UED_VENDOR_CLASS;
				4'd7:  rom_byte = `UED_VENDOR_CLASS;
				4'd9:  rom_byte = 8'h07;
				4'd10: rom_byte = `UED_DT_EP;
				4'd11: rom_byte = `UED_EP_ADDR;
				4'd12: rom_byte = `UED_EP_ISO;
				4'd13: rom_byte = mps[7:0];
				4'd14: rom_byte = mps[15:8];
				4'd15: rom_byte = `UED_EP_INTERVAL;
				default: rom_byte = 8'h00;
			endcase
		end
	end
	always @(posedge ref_clk_i) begin
		data_o <= rom_byte;
	end
endmodule // ued_desc_rom

// file: ued_responder.v
// descriptor responder behind control endpoint 0
//
// Behaviour
// R01 - device descriptor: 18 bytes, type 1, USB 1.00, class fields zero
// R02 - device descriptor reports 8-byte control endpoint packets
// R03 - string indices zero, device release 1.00 in BCD
// R04 - exactly one configuration declared
// R05 - product id chosen from variant strap and five data strap bits
// R06 - configuration request accepts index 00 only, else stall
// R07 - configuration bundle is 73 bytes, same as total-length field
// R08 - configuration: 9 bytes, type 2, one interface, value 1, no string
// R09 - attributes mark bus powered without remote wakeup
// R10 - max power 400 mA coded as 0xc8
// R11 - four interface alternates, interface 1, vendor class, one endpoint
// R12 - each followed by 7-byte isochronous IN endpoint 0x81, interval 1
// R13 - bandwidth strap high gives 0, 448, 704, 960 bytes
// R14 - bandwidth strap low gives 0, 320, 616, 896 bytes
// R15 - string 0 is 14 bytes listing six language ids in order
// R16 - every string index above zero returns 22-byte camera name
// R17 - host finishes enumeration with 255-byte configuration request
// R18 - data goes in 8-byte packets, last one may be short
// R19 - unknown or unprocessable requests are stalled; a setup during a transfer is dropped without stall
// R20 - bandwidth strap defaults high when left open
// R21 - reply truncated to requested length or descriptor length
// R22 - straps sampled after reset and held until next reset
`timescale 1ns/1ps
`include "ued_consts.vh"
module ued_responder #(
	parameter [15:0] VENDOR_ID       = 16'h1234,
	// arbitrary neutral identity values
	parameter [15:0] PRODUCT_ID_BASE = 16'h0100,
	parameter [15:0] PRODUCT_ID_DFLT = 16'h0001
) (
	input  wire        ref_clk_i,
	input  wire        rstn_i,
	input  wire        setup_valid_i,
	input  wire [7:0]  bm_request_type_i,
	input  wire [7:0]  b_request_i,
	input  wire [15:0] w_value_i,
	input  wire [15:0] w_length_i,
	input  wire        in_token_i,
	input  wire        product_variant_strap_i,
	input  wire [4:0]  host_port_data_strap_bits_i,
	input  wire        bandwidth_set_strap_i,
	output reg         tx_valid_o,
	output reg  [7:0]  tx_data_o,
	output reg         tx_last_o,
	output reg         stall_o,
	output reg         busy_o
);
	localparam [1:0] ST_IDLE  = 2'd0;
	localparam [1:0] ST_FETCH = 2'd1;
	localparam [1:0] ST_SEND  = 2'd2;
	localparam [1:0] ST_WAIT  = 2'd3;

	reg  [1:0]  state_reg, state_next;
	reg  [7:0]  base_reg, base_next;
	reg  [7:0]  left_reg, left_next;
	reg  [7:0]  idx_reg, idx_next;
	reg  [3:0]  pkt_reg, pkt_next;
	reg         stall_next;
	reg         straps_taken_reg;
	reg         variant_reg;
	reg  [4:0]  dbits_reg;
	reg         bw_low_reg;
	reg  [15:0] product_id_reg;
	reg  [7:0]  desc_len;
	reg  [7:0]  want;
	reg         known;
	wire [7:0]  rom_data;

	////////////////////////////////////////////////////////////////////////
	// R22 straps held
	// sampled on the first clock after reset so no port feeds a reset value
	always @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			straps_taken_reg <= 1'b0;
			variant_reg      <= 1'b1;
			dbits_reg        <= 5'h00;
			bw_low_reg       <= 1'b0;
			product_id_reg   <= PRODUCT_ID_DFLT;
		end else if (!straps_taken_reg) begin
			straps_taken_reg <= 1'b1;
			variant_reg      <= product_variant_strap_i;
			dbits_reg        <= host_port_data_strap_bits_i;
			// R20 open pin reads high
			bw_low_reg       <= ~bandwidth_set_strap_i;
		end else begin
			// R05 product product_variant_strap
			// built from the held copies, settled long before the first in token
			product_id_reg   <= variant_reg ? PRODUCT_ID_DFLT : (PRODUCT_ID_BASE | {11'h000, dbits_reg});
		end
	end

	////////////////////////////////////////////////////////////////////////
	// request decode
	always @* begin
		known = 1'b0;
		desc_len = 8'h00;
		base_next = base_reg;
		if (bm_request_type_i == `UED_RT_DEV_IN && b_request_i == `UED_REQ_GET_DESC) begin
			case (w_value_i[15:8])
				`UED_DT_DEVICE: begin
					// R01 device record
					known = 1'b1;
					desc_len = `UED_DEV_LEN;
					base_next = `UED_ROM_DEV;
				end
				`UED_DT_CONFIG: begin
					// R06 index 00 only
					known = (w_value_i[7:0] == 8'h00);
					// R07 whole bundle
					desc_len = `UED_CFG_TOTAL;
					base_next = `UED_ROM_CFG;
				end
				`UED_DT_STRING: begin
					known = 1'b1;
					// R15 R16 string select
					desc_len = (w_value_i[7:0] == 8'h00) ? `UED_STR0_LEN : `UED_STRN_LEN;
					base_next = (w_value_i[7:0] == 8'h00) ? `UED_ROM_STR0 : `UED_ROM_STRN;
				end
				default: known = 1'b0;
			endcase
		end
		// R21 truncate to request
		want = (w_length_i < {8'h00, desc_len}) ? w_length_i[7:0] : desc_len;
	end

	////////////////////////////////////////////////////////////////////////
	// transmit sequencer
	always @* begin
		state_next = state_reg;
		left_next  = left_reg;
		idx_next   = idx_reg;
		pkt_next   = pkt_reg;
		stall_next = 1'b0;
		case (state_reg)
			ST_IDLE: begin
				if (setup_valid_i) begin
					if (!known) begin
						// R19 stall unknown
						stall_next = 1'b1;
					end else if (want == 8'h00) begin
						state_next = ST_IDLE;
					end else begin
						left_next  = want;
						idx_next   = base_next;
						state_next = ST_WAIT;
					end
				end
			end
			ST_WAIT: begin
				if (setup_valid_i) begin
					// new setup aborts the old transfer
					state_next = ST_IDLE;
				end else if (in_token_i) begin
					pkt_next   = 4'h0;
					state_next = ST_FETCH;
				end
			end
			ST_FETCH: begin
				idx_next   = idx_reg + 8'h01;
				state_next = ST_SEND;
			end
			ST_SEND: begin
				left_next = left_reg - 8'h01;
				pkt_next  = pkt_reg + 4'h1;
				// R18 eight-byte packets
				if (left_reg == 8'h01)
					state_next = ST_IDLE;
				else if (pkt_reg == `UED_PKT_BYTES - 4'h1)
					state_next = ST_WAIT;
				else
					state_next = ST_FETCH;
			end
			default: state_next = ST_IDLE;
		endcase
	end

	always @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			state_reg  <= ST_IDLE;
			base_reg   <= 8'h00;
			left_reg   <= 8'h00;
			idx_reg    <= 8'h00;
			pkt_reg    <= 4'h0;
			stall_o    <= 1'b0;
			tx_valid_o <= 1'b0;
			tx_last_o  <= 1'b0;
			tx_data_o  <= 8'h00;
			busy_o     <= 1'b0;
		end else begin
			state_reg  <= state_next;
			base_reg   <= base_next;
			left_reg   <= left_next;
			idx_reg    <= idx_next;
			pkt_reg    <= pkt_next;
			stall_o    <= stall_next;
			tx_valid_o <= (state_reg == ST_SEND);
			tx_data_o  <= (state_reg == ST_SEND) ? rom_data : 8'h00;
			tx_last_o  <= (state_reg == ST_SEND) &&
				(left_reg == 8'h01 || pkt_reg == `UED_PKT_BYTES - 4'h1);
			busy_o     <= (state_next != ST_IDLE);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// R02 R03 R04 R08 R09 R10 R11 R12 R13 R14 table content
	ued_desc_rom u_rom (
		.ref_clk_i    (ref_clk_i),
		.addr_i       (idx_reg),
		.vendor_id_i  (VENDOR_ID),
		.product_id_i (product_id_reg),
		.bw_low_i     (bw_low_reg),
		.data_o       (rom_data)
	);
endmodule // ued_responder

// file: ued_responder_chk.sv
// concurrent checks on the descriptor responder ports
`timescale 1ns/1ps
module ued_responder_chk (
	input logic        ref_clk_i,
	input logic        rstn_i,
	input logic        setup_valid_i,
	input logic [7:0]  bm_request_type_i,
	input logic [7:0]  b_request_i,
	input logic [15:0] w_value_i,
	input logic [15:0] w_length_i,
	input logic        in_token_i,
	input logic        product_variant_strap_i,
	input logic [4:0]  host_port_data_strap_bits_i,
	input logic        bandwidth_set_strap_i,
	input logic        tx_valid_o,
	input logic [7:0]  tx_data_o,
	input logic        tx_last_o,
	input logic        stall_o,
	input logic        busy_o
);
default clocking cb @(posedge ref_clk_i); endclocking
default disable iff (!rstn_i);
logic [2:0] pkt_cnt;
wire        get_w = setup_valid_i && !busy_o && bm_request_type_i == 8'h80 && b_request_i == 8'h06;
//////////////////////////////////////////////////////////////////////////////
// bytes within the current packet, cleared by each setup or packet end
always @(posedge ref_clk_i)
	if (!rstn_i || setup_valid_i || tx_last_o) pkt_cnt <= 3'h0;
	else if (tx_valid_o) pkt_cnt <= pkt_cnt + 3'h1;
//////////////////////////////////////////////////////////////////////////////
stall_cfg_a: assert property (get_w && w_value_i[15:8] == 8'h02 && w_value_i[7:0] != 8'h00 |=> stall_o)
	else $error("bad config index");
stall_req_a: assert property (setup_valid_i && !busy_o && b_request_i != 8'h06 |=> stall_o)
	else $error("unknown request not stalled");
stall_one_a: assert property (stall_o |=> !stall_o) else $error("stall longer than one cycle");
dev_take_a: assert property (get_w && w_value_i == 16'h0100 && w_length_i != 16'h0 |=> busy_o && !stall_o)
	else $error("device request not taken");
zero_len_a: assert property (get_w && w_length_i == 16'h0 &&
	(w_value_i[15:8] == 8'h01 || w_value_i[15:8] == 8'h03 || w_value_i == 16'h0200) |=> !stall_o ##1 !tx_valid_o)
	else $error("zero length misbehaves");
byte_gap_a: assert property (tx_valid_o |=> !tx_valid_o) else $error("bytes closer than two cycles");
pkt_last_a: assert property (tx_valid_o && pkt_cnt == 3'h7 |-> tx_last_o) else $error("packet over 8 bytes");
last_val_a: assert property (tx_last_o |-> tx_valid_o) else $error("last without byte");
valid_busy_a: assert property (tx_valid_o && !tx_last_o |-> busy_o) else $error("byte outside transfer");
idle_data_a: assert property (!tx_valid_o |-> tx_data_o == 8'h00) else $error("data not zero idle");
cover property (get_w && w_value_i[15:8] == 8'h02 ##1 busy_o);
cover property (tx_last_o && pkt_cnt == 3'h7);
cover property (stall_o);
endmodule // ued_responder_chk
bind ued_responder ued_responder_chk chk (.*);

// file: ued_host_model.sv
// host controller model issuing control read transfers
`timescale 1ns/1ps
module ued_host_model (
	input  logic        ref_clk_i,
	input  logic [2:0]  gap_i,
	input  logic        tx_last_i,
	input  logic        busy_i,
	output logic        setup_valid_o = 1'b0,
	output logic [7:0]  bm_request_type_o = 8'h00,
	output logic [7:0]  b_request_o = 8'h00,
	output logic [15:0] w_value_o = 16'h0000,
	output logic [15:0] w_length_o = 16'h0000,
	output logic        in_token_o = 1'b0
);
int hang = 0;
// bounded wait for packet end or for the transfer to finish
task automatic wait_for(input logic last);
	int k;
	k = 0;
	while (!(last ? tx_last_i : !busy_i) && k < 60) begin
		@(negedge ref_clk_i);
		k++;
	end
	if (k >= 60) hang++;
endtask
// setup then one in token per packet
task automatic xfer(input logic [7:0] rq, input logic [15:0] val, len, input int npk);
	@(negedge ref_clk_i);
	setup_valid_o = 1'b1;
	{bm_request_type_o, b_request_o, w_value_o, w_length_o} = {8'h80, rq, val, len};
	@(negedge ref_clk_i);
	setup_valid_o = 1'b0;
	// fields no longer qualified, so they must not look valid
	{b_request_o, w_value_o, w_length_o} = ~{b_request_o, w_value_o, w_length_o};
	for (int p = 0; p < npk; p++) begin
		repeat (gap_i) @(negedge ref_clk_i);
		in_token_o = 1'b1;
		@(negedge ref_clk_i);
		in_token_o = 1'b0;
		wait_for(1'b1);
	end
	wait_for(1'b0);
endtask
endmodule // ued_host_model

// file: tb_usb_enum_descriptor_responder.sv
// self-checking bench for the descriptor responder
`timescale 1ns/1ps
module tb_usb_enum_descriptor_responder;
// arbitrary identity values
localparam [15:0] VID = 16'h5a3c, PID_D = 16'h0007, PID_B = 16'h0200;
logic        clk = 1'b0, rstn = 1'b0, var_s = 1'b1, bw_s = 1'b1, st_seen, v_var, v_bw;
logic [4:0]  bits_s = 5'h00, v_bits;
logic [2:0]  gap = 3'h0;
logic [31:0] seed = 32'h17a0;
logic [15:0] pid, m;
wire         sv, tok, tv, tl, st, bz;
wire  [7:0]  rt, rq, td;
wire  [15:0] wv, wl;
int          fail_count = 0, n_compared = 0;
logic [8:0]  exp_q[$];
logic [7:0]  d[$];
string       txt = "USB Camera";
initial forever #20 clk = ~clk;
ued_host_model host (.ref_clk_i(clk), .gap_i(gap), .tx_last_i(tl), .busy_i(bz), .setup_valid_o(sv),
	.bm_request_type_o(rt), .b_request_o(rq), .w_value_o(wv), .w_length_o(wl), .in_token_o(tok));
ued_responder #(.VENDOR_ID(VID), .PRODUCT_ID_BASE(PID_B), .PRODUCT_ID_DFLT(PID_D)) dut (.ref_clk_i(clk),
	.rstn_i(rstn), .setup_valid_i(sv), .bm_request_type_i(rt), .b_request_i(rq), .w_value_i(wv),
	.w_length_i(wl), .in_token_i(tok), .product_variant_strap_i(var_s), .host_port_data_strap_bits_i(bits_s),
	.bandwidth_set_strap_i(bw_s), .tx_valid_o(tv), .tx_data_o(td), .tx_last_o(tl), .stall_o(st), .busy_o(bz));
//////////////////////////////////////////////////////////////////////////////
function automatic logic [31:0] xs(input logic [31:0] s);
	s ^= s << 13;
	s ^= s >> 17;
	s ^= s << 5;
	return s;
endfunction
task automatic cmp(input string nm, input logic [8:0] e, g);
	n_compared++;
	if (g !== e) begin
		fail_count++;
		$display("wrong value %s expected %h seen %h", nm, e, g);
	end
endtask
task automatic print_verdict;
	fail_count += host.hang;
	$display("compared %0d mismatches %0d", n_compared, fail_count);
	if (fail_count == 0 && n_compared > 0) $display("All tests passed");
	else $display("Some tests failed");
	$finish;
endtask
// queue the expected bytes, run the transfer, then check stall and leftovers
task automatic req(input logic [7:0] r, input logic [15:0] val, len, input logic stall_e);
	int n;
	n = (len < d.size()) ? len : d.size();
	for (int i = 0; i < n; i++) exp_q.push_back({i % 8 == 7 || i == n - 1, d[i]});
	seed = xs(seed);
	gap = seed[2:0];
	st_seen = 1'b0;
	host.xfer(r, val, len, (n + 7) / 8);
	// let the watcher take the last byte and any stall before judging
	@(negedge clk);
	cmp("stall", {8'h00, stall_e}, {8'h00, st_seen}); // stall when due
	cmp("bytes left", 9'h000, exp_q.size()); // reply length
	if (host.hang != 0) print_verdict();
endtask
//////////////////////////////////////////////////////////////////////////////
always @(negedge clk) begin
	if (st) st_seen = 1'b1;
	if (tv && exp_q.size() == 0) cmp("surplus byte", 'x, {tl, td}); // no extra bytes
	else if (tv) cmp("desc byte", exp_q.pop_front(), {tl, td}); // bytes and packet ends
end
initial begin
	for (int p = 0; p < 3; p++) begin
		seed = xs(seed);
		rstn = 1'b0;
		{var_s, bw_s, bits_s} = {p != 1, p == 0, seed[4:0]};
		repeat (12) @(negedge clk);
		rstn = 1'b1;
		@(negedge clk);
		{v_var, v_bw, v_bits} = {var_s, bw_s, bits_s};
		// straps move after sampling and must be ignored
		{var_s, bw_s, bits_s} = ~{var_s, bw_s, bits_s};
		pid = v_var ? PID_D : (PID_B | {11'h0, v_bits});
		d = '{8'h12, 8'h01, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h08, VID[7:0], VID[15:8], pid[7:0], pid[15:8],
			8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h01};
		req(8'h06, 16'h0100, 16'h0040, 1'b0); // device record
		req(8'h06, 16'h0100, 16'h0008, 1'b0); // truncated to request
		req(8'h06, 16'h0100, 16'h0000, 1'b0); // zero length
		d = '{8'h09, 8'h02, 8'h49, 8'h00, 8'h01, 8'h01, 8'h00, 8'h80, 8'hc8};
		for (int a = 0; a < 4; a++) begin
			m = (a == 0) ? 16'h0 : v_bw ? 16'h0100 * a[15:0] + 16'h00c0 : {16'h0140, 16'h0268, 16'h0380} >> (48 - 16 * a);
			d = {d, 8'h09, 8'h04, 8'h01, a[7:0], 8'h01, 8'hff, 8'h00, 8'hff, 8'h00, 8'h07, 8'h05, 8'h81, 8'h01,
				m[7:0], m[15:8], 8'h01};
		end
		req(8'h06, 16'h0200, 16'h00ff, 1'b0); // bundle
		d.delete();
		req(8'h06, {8'h02, seed[15:8] | 8'h01}, 16'h00ff, 1'b1); // bad index
		req(8'h01, 16'h0100, 16'h0012, 1'b1); // unknown request
		d = '{8'h0e, 8'h03, 8'h04, 8'h09, 8'h04, 8'h0c, 8'h04, 8'h07, 8'h04, 8'h10, 8'h0c, 8'h0a, 8'h04, 8'h16};
		req(8'h06, 16'h0300, 16'h00ff, 1'b0); // language list
		d = '{8'h16, 8'h03};
		foreach (txt[i]) d = {d, txt[i], 8'h00};
		req(8'h06, {8'h03, seed[23:16] | 8'h01}, 16'h00ff, 1'b0); // camera name
	end
	print_verdict();
end
endmodule // tb_usb_enum_descriptor_responder
